// ### rtl/crs_req_framer.v
/*
 * Completer request stream framer: turns a parsed request header and its
 * payload dwords into a 128-bit descriptor plus payload on a 256-bit stream.
 * Assumes header and payload come from logic on core_clk, payload dwords
 * in order, exactly dw_count of them when has_data is set.
 */
`timescale 1ns/1ps
`include "crs_regs.vh"
module crs_req_framer (
	input wire core_clk,
	input wire reset_n,
	input wire addr_aligned_mode,
	input wire hdr_valid,
	output reg hdr_ready,
	input wire [3:0] hdr_type,
	input wire hdr_has_data,
	input wire [63:0] hdr_addr,
	input wire [10:0] hdr_dw_count,
	input wire [15:0] hdr_req_id,
	input wire [7:0] hdr_tag,
	input wire [7:0] hdr_func,
	input wire [2:0] hdr_bar_id,
	input wire [2:0] hdr_tc,
	input wire [2:0] hdr_attr,
	input wire [3:0] hdr_first_dword_enables,
	input wire [3:0] hdr_last_be,
	input wire [7:0] hdr_msg_code,
	input wire [2:0] hdr_msg_route,
	input wire [31:0] hdr_dw2,
	input wire [31:0] hdr_dw3,
	input wire hdr_tph_present,
	input wire [1:0] hdr_tph_type,
	input wire [7:0] hdr_tph_tag,
	input wire pay_valid,
	output wire pay_ready,
	input wire [31:0] pay_dword,
	output wire req_stream_valid,
	input wire req_stream_ready,
	output wire [`CRS_DATA_W-1:0] req_stream_data,
	output wire [`CRS_KEEP_W-1:0] req_stream_dword_keep,
	output wire req_stream_last,
	output wire [`CRS_USER_W-1:0] req_stream_sideband,
	output reg dropped_req
);

// ***************************************************
// Type decoding
// ***************************************************
function is_msg;
	input [3:0] t;
	begin
		is_msg = (t == `CRS_T_MSG) || (t == `CRS_T_MSG_VEND) ||
			(t == `CRS_T_MSG_ATS);
	end
endfunction

// Configuration and reserved codes must not reach the completer user
function type_ok;
	input [3:0] t;
	begin
		type_ok = (t <= `CRS_T_LOCKED_RD) || is_msg(t);
	end
endfunction

localparam S_IDLE = 2'd0;
localparam S_DESC = 2'd1;
localparam S_PAY = 2'd2;
localparam S_DROP = 2'd3;

reg [1:0] state_r;
reg [1:0] state_nxt;
reg [3:0] type_r;
reg has_data_r;
reg aa_mode_r;
reg [63:0] addr_r;
reg [10:0] dw_count_r;
reg [15:0] req_id_r;
reg [7:0] tag_r;
reg [7:0] func_r;
reg [2:0] bar_r;
reg [2:0] tc_r;
reg [2:0] attr_r;
reg [3:0] fbe_r;
reg [3:0] lbe_r;
reg [7:0] code_r;
reg [2:0] route_r;
reg [31:0] dw2_r;
reg [31:0] dw3_r;
reg tph_r;
reg [1:0] tph_type_r;
reg [7:0] tph_tag_r;

reg [`CRS_DATA_W-1:0] asm_data_r;
reg [`CRS_KEEP_W-1:0] asm_keep_r;
reg [`CRS_USER_W-1:0] asm_user_r;
reg asm_last_r;
reg asm_full_r;
reg [`CRS_KEEP_W-1:0] keep_init_r;
reg [2:0] lane_r;
reg [10:0] remain_r;
reg first_dw_r;
reg [`CRS_DESC_W-1:0] desc;
reg [3:0] dw_be;
reg [`CRS_KEEP_W-1:0] gap_mask;
reg [2:0] start_lane;
integer i;

wire buf_in_ready;
wire buf_push;
wire pay_take;
wire [`CRS_BEAT_W-1:0] buf_out;
wire st_wr;
wire st_rd;
wire [`CRS_BEAT_W-1:0] st_out;
reg [`CRS_BEAT_W-1:0] store_mem [0:(1<<`CRS_STORE_AW)-1];
reg [`CRS_STORE_AW-1:0] wr_ptr_r;
reg [`CRS_STORE_AW-1:0] rd_ptr_r;
reg [`CRS_STORE_AW:0] fill_r;
reg [`CRS_STORE_AW:0] pkts_r;

// Beats reach the buffer only once their whole packet is in the store
assign st_wr = asm_full_r && !fill_r[`CRS_STORE_AW];
assign st_out = store_mem[rd_ptr_r];
assign buf_push = (pkts_r != {(`CRS_STORE_AW+1){1'b0}});
assign st_rd = buf_push && buf_in_ready;
assign pay_ready = ((state_r == S_PAY) && !asm_full_r) ||
	(state_r == S_DROP);
assign pay_take = pay_valid && pay_ready;

// ***************************************************
// Descriptor assembly
// ***************************************************
always @* begin
	desc = {`CRS_DESC_W{1'b0}};
	desc[`CRS_D_DWCNT_HI:`CRS_D_DWCNT_LO] = dw_count_r;
	desc[`CRS_D_TYPE_HI:`CRS_D_TYPE_LO] = type_r;
	desc[`CRS_D_REQID_HI:`CRS_D_REQID_LO] = req_id_r;
	desc[`CRS_D_TAG_HI:`CRS_D_TAG_LO] = tag_r;
	desc[`CRS_D_TC_HI:`CRS_D_TC_LO] = tc_r;
	desc[`CRS_D_ATTR_HI:`CRS_D_ATTR_LO] = attr_r;
	if (is_msg(type_r)) begin
		desc[`CRS_D_CODE_HI:`CRS_D_CODE_LO] = code_r;
		desc[`CRS_D_ROUTE_HI:`CRS_D_ROUTE_LO] = route_r;
		if (type_r == `CRS_T_MSG_VEND) begin
			desc[63:32] = dw3_r;
			if (route_r == `CRS_ROUTE_BY_ID)
				desc[`CRS_D_DEST_HI:`CRS_D_DEST_LO] = dw2_r[31:16];
		end else if (type_r == `CRS_T_MSG_ATS) begin
			desc[63:0] = {dw3_r, dw2_r};
		end else if (code_r == `CRS_MSG_OBFF) begin
			desc[`CRS_D_OBFF_HI:`CRS_D_OBFF_LO] = dw3_r[3:0];
		end else begin
			desc[63:0] = {dw3_r, dw2_r};
		end
	end else begin
		desc[`CRS_D_ADDR_HI:`CRS_D_ADDR_LO] = addr_r[63:2];
		desc[`CRS_D_CODE_HI:`CRS_D_CODE_LO] = func_r;
		desc[`CRS_D_ROUTE_HI:`CRS_D_ROUTE_LO] = bar_r;
	end
end

// Payload byte enables: first dword wins for a one-dword write, so a
// zero-length write with first_dword_enables of 0 shows no enables at all
always @* begin
	if (first_dw_r)
		dw_be = fbe_r;
	else if (remain_r == 11'd1)
		dw_be = lbe_r;
	else
		dw_be = 4'hf;
end

// Messages always start at lane 0 in address-aligned mode
always @* begin
	start_lane = is_msg(type_r) ? 3'd0 : addr_r[4:2];
	gap_mask = {`CRS_KEEP_W{1'b0}};
	for (i = 0; i < `CRS_KEEP_W; i = i + 1)
		gap_mask[i] = (i < start_lane);
end

// ***************************************************
// State machine
// ***************************************************
always @* begin
	state_nxt = state_r;
	case (state_r)
	S_IDLE: begin
		if (hdr_valid && hdr_ready)
			state_nxt = type_ok(hdr_type) ? S_DESC :
				(hdr_has_data ? S_DROP : S_IDLE);
	end
	S_DESC: begin
		if (!asm_full_r)
			state_nxt = has_data_r ? S_PAY : S_IDLE;
	end
	S_PAY: begin
		if (pay_take && remain_r == 11'd1)
			state_nxt = S_IDLE;
	end
	S_DROP: begin
		if (pay_take && remain_r == 11'd1)
			state_nxt = S_IDLE;
	end
	default: state_nxt = S_IDLE;
	endcase
end

always @(posedge core_clk or negedge reset_n) begin
	if (!reset_n) begin
		state_r <= S_IDLE;
		hdr_ready <= 1'b0;
		dropped_req <= 1'b0;
		type_r <= 4'h0;
		has_data_r <= 1'b0;
		aa_mode_r <= 1'b0;
		addr_r <= 64'h0;
		dw_count_r <= 11'h0;
		req_id_r <= 16'h0;
		tag_r <= 8'h0;
		func_r <= 8'h0;
		bar_r <= 3'h0;
		tc_r <= 3'h0;
		attr_r <= 3'h0;
		fbe_r <= 4'h0;
		lbe_r <= 4'h0;
		code_r <= 8'h0;
		route_r <= 3'h0;
		dw2_r <= 32'h0;
		dw3_r <= 32'h0;
		tph_r <= 1'b0;
		tph_type_r <= 2'h0;
		tph_tag_r <= 8'h0;
		remain_r <= 11'h0;
	end else begin
		state_r <= state_nxt;
		hdr_ready <= (state_nxt == S_IDLE) && !(hdr_valid && hdr_ready);
		dropped_req <= hdr_valid && hdr_ready && !type_ok(hdr_type);
		if (hdr_valid && hdr_ready) begin
			type_r <= hdr_type;
			has_data_r <= hdr_has_data;
			aa_mode_r <= addr_aligned_mode;
			addr_r <= hdr_addr;
			dw_count_r <= hdr_dw_count;
			req_id_r <= hdr_req_id;
			tag_r <= hdr_tag;
			func_r <= hdr_func;
			bar_r <= hdr_bar_id;
			tc_r <= hdr_tc;
			attr_r <= hdr_attr;
			fbe_r <= hdr_first_dword_enables;
			lbe_r <= hdr_last_be;
			code_r <= hdr_msg_code;
			route_r <= hdr_msg_route;
			dw2_r <= hdr_dw2;
			dw3_r <= hdr_dw3;
			tph_r <= hdr_tph_present;
			tph_type_r <= hdr_tph_type;
			tph_tag_r <= hdr_tph_tag;
			remain_r <= hdr_dw_count;
		end else if (pay_take) begin
			remain_r <= remain_r - 11'd1;
		end
	end
end

// ***************************************************
// Beat assembly
// ***************************************************
always @(posedge core_clk or negedge reset_n) begin
	if (!reset_n) begin
		asm_data_r <= {`CRS_DATA_W{1'b0}};
		asm_keep_r <= {`CRS_KEEP_W{1'b0}};
		asm_user_r <= {`CRS_USER_W{1'b0}};
		asm_last_r <= 1'b0;
		asm_full_r <= 1'b0;
		keep_init_r <= {`CRS_KEEP_W{1'b0}};
		lane_r <= 3'd0;
		first_dw_r <= 1'b0;
	end else if (asm_full_r) begin
		// Hold the beat until the store takes it
		if (st_wr) begin
			asm_full_r <= 1'b0;
			asm_last_r <= 1'b0;
			asm_data_r <= {`CRS_DATA_W{1'b0}};
			asm_user_r <= {`CRS_USER_W{1'b0}};
			asm_keep_r <= keep_init_r;
			keep_init_r <= {`CRS_KEEP_W{1'b0}};
		end
	end else if (state_r == S_DESC) begin
		asm_data_r[`CRS_DESC_W-1:0] <= desc;
		asm_keep_r <= 8'h0f;
		asm_user_r[`CRS_U_SOP] <= 1'b1;
		asm_user_r[`CRS_U_FBE_HI:`CRS_U_FBE_LO] <= fbe_r;
		asm_user_r[`CRS_U_LBE_HI:`CRS_U_LBE_LO] <= lbe_r;
		asm_user_r[`CRS_U_TPH_PRES] <= tph_r;
		asm_user_r[`CRS_U_TPH_TYPE_HI:`CRS_U_TPH_TYPE_LO] <= tph_type_r;
		asm_user_r[`CRS_U_TPH_TAG_HI:`CRS_U_TPH_TAG_LO] <= tph_tag_r;
		first_dw_r <= 1'b1;
		if (!has_data_r) begin
			asm_full_r <= 1'b1;
			asm_last_r <= 1'b1;
		end else if (aa_mode_r) begin
			// Gap lanes after the descriptor count as kept
			asm_keep_r <= 8'hff;
			asm_full_r <= 1'b1;
			lane_r <= start_lane;
			keep_init_r <= gap_mask;
		end else begin
			lane_r <= 3'd4;
		end
	end else if (state_r == S_PAY && pay_take) begin
		asm_data_r[lane_r*32 +: 32] <= pay_dword;
		asm_keep_r[lane_r] <= 1'b1;
		asm_user_r[`CRS_U_BEN_LO + lane_r*4 +: 4] <= dw_be;
		first_dw_r <= 1'b0;
		lane_r <= lane_r + 3'd1;
		if (remain_r == 11'd1 || lane_r == 3'd7)
			asm_full_r <= 1'b1;
		if (remain_r == 11'd1)
			asm_last_r <= 1'b1;
	end
end

// ***************************************************
// Packet store
// ***************************************************
// Payload fills a beat a dword per cycle while the stream drains a beat
// per cycle, so a packet is held whole before its first beat leaves.
// Limitation: a packet of more beats than the store holds never leaves.
always @(posedge core_clk) begin
	if (st_wr)
		store_mem[wr_ptr_r] <=
			{asm_last_r, asm_user_r, asm_keep_r, asm_data_r};
end

always @(posedge core_clk or negedge reset_n) begin
	if (!reset_n) begin
		wr_ptr_r <= {`CRS_STORE_AW{1'b0}};
		rd_ptr_r <= {`CRS_STORE_AW{1'b0}};
		fill_r <= {(`CRS_STORE_AW+1){1'b0}};
		pkts_r <= {(`CRS_STORE_AW+1){1'b0}};
	end else begin
		if (st_wr)
			wr_ptr_r <= wr_ptr_r + 1'b1;
		if (st_rd)
			rd_ptr_r <= rd_ptr_r + 1'b1;
		fill_r <= fill_r + {{`CRS_STORE_AW{1'b0}}, st_wr} -
			{{`CRS_STORE_AW{1'b0}}, st_rd};
		pkts_r <= pkts_r + {{`CRS_STORE_AW{1'b0}}, st_wr && asm_last_r} -
			{{`CRS_STORE_AW{1'b0}}, st_rd && st_out[`CRS_BEAT_W-1]};
	end
end

// ***************************************************
// Output buffer
// ***************************************************
// Stream outputs come from the buffer's registers; valid stays high
// across a packet since only whole packets are released from the store
crs_skid_buf #(
	.W(`CRS_BEAT_W)
) u_buf (
	.core_clk(core_clk),
	.reset_n(reset_n),
	.in_valid(buf_push),
	.in_ready(buf_in_ready),
	.in_data(st_out),
	.out_valid(req_stream_valid),
	.out_ready(req_stream_ready),
	.out_data(buf_out)
);

assign req_stream_data = buf_out[`CRS_DATA_W-1:0];
assign req_stream_dword_keep =
	buf_out[`CRS_DATA_W+`CRS_KEEP_W-1:`CRS_DATA_W];
assign req_stream_sideband = buf_out[`CRS_BEAT_W-2:`CRS_DATA_W+`CRS_KEEP_W];
assign req_stream_last = buf_out[`CRS_BEAT_W-1];

endmodule // crs_req_framer

// ### common/crs_regs.vh
/*
 * Constants of the completer request stream framer: stream widths,
 * descriptor field positions, request type codes and sideband layout.
 * Assumes it is included by bare name by every design file that uses it.
 */
`ifndef CRS_REGS_VH
`define CRS_REGS_VH

// ***************************************************
// Widths
// ***************************************************
`define CRS_DATA_W 256
`define CRS_KEEP_W 8
`define CRS_USER_W 52
`define CRS_DESC_W 128
`define CRS_BEAT_W 317
`define CRS_STORE_AW 8

// ***************************************************
// Descriptor fields
// ***************************************************
`define CRS_D_ADDR_HI 63
`define CRS_D_ADDR_LO 2
`define CRS_D_DWCNT_HI 74
`define CRS_D_DWCNT_LO 64
`define CRS_D_TYPE_HI 78
`define CRS_D_TYPE_LO 75
`define CRS_D_REQID_HI 95
`define CRS_D_REQID_LO 80
`define CRS_D_TAG_HI 103
`define CRS_D_TAG_LO 96
`define CRS_D_CODE_HI 111
`define CRS_D_CODE_LO 104
`define CRS_D_ROUTE_HI 114
`define CRS_D_ROUTE_LO 112
`define CRS_D_TC_HI 123
`define CRS_D_TC_LO 121
`define CRS_D_ATTR_HI 126
`define CRS_D_ATTR_LO 124
`define CRS_D_OBFF_HI 35
`define CRS_D_OBFF_LO 32
`define CRS_D_DEST_HI 15
`define CRS_D_DEST_LO 0

// ***************************************************
// Request types and message constants
// ***************************************************
`define CRS_T_MEM_RD 4'h0
`define CRS_T_MEM_WR 4'h1
`define CRS_T_IO_RD 4'h2
`define CRS_T_IO_WR 4'h3
`define CRS_T_FETCH_ADD 4'h4
`define CRS_T_SWAP 4'h5
`define CRS_T_CAS 4'h6
`define CRS_T_LOCKED_RD 4'h7
`define CRS_T_CFG_FIRST 4'h8
`define CRS_T_CFG_LAST 4'hb
`define CRS_T_MSG 4'hc
`define CRS_T_MSG_VEND 4'hd
`define CRS_T_MSG_ATS 4'he
`define CRS_T_RESERVED 4'hf
`define CRS_ROUTE_BY_ID 3'h2
`define CRS_MSG_OBFF 8'h12
`define CRS_OBFF_ACTIVE 4'hf
`define CRS_OBFF_PATH 4'h1
`define CRS_OBFF_IDLE 4'h0

// ***************************************************
// Sideband layout
// ***************************************************
`define CRS_U_FBE_HI 3
`define CRS_U_FBE_LO 0
`define CRS_U_LBE_HI 7
`define CRS_U_LBE_LO 4
`define CRS_U_BEN_HI 39
`define CRS_U_BEN_LO 8
`define CRS_U_SOP 40
`define CRS_U_TPH_PRES 41
`define CRS_U_TPH_TYPE_HI 43
`define CRS_U_TPH_TYPE_LO 42
`define CRS_U_TPH_TAG_HI 51
`define CRS_U_TPH_TAG_LO 44

`endif

// ### rtl/crs_skid_buf.v
/*
 * Two-entry skid buffer between the packet store and the stream port.
 * Assumes one clock; source honours in_ready, which is registered.
 */
`timescale 1ns/1ps
module crs_skid_buf #(
	parameter W = 8
) (
	input wire core_clk,
	input wire reset_n,
	input wire in_valid,
	output reg in_ready,
	input wire [W-1:0] in_data,
	output reg out_valid,
	input wire out_ready,
	output reg [W-1:0] out_data
);

reg skid_valid_r;
reg [W-1:0] skid_data_r;

// Output stays put while stalled, so a held beat never changes
always @(posedge core_clk or negedge reset_n) begin
	if (!reset_n) begin
		out_valid <= 1'b0;
		out_data <= {W{1'b0}};
		skid_valid_r <= 1'b0;
		skid_data_r <= {W{1'b0}};
		in_ready <= 1'b1;
	end else begin
		if (out_ready || !out_valid) begin
			if (skid_valid_r) begin
				out_valid <= 1'b1;
				out_data <= skid_data_r;
				skid_valid_r <= 1'b0;
				in_ready <= 1'b1;
			end else begin
				out_valid <= in_valid && in_ready;
				if (in_valid && in_ready)
					out_data <= in_data;
			end
		end else if (in_valid && in_ready) begin
			skid_valid_r <= 1'b1;
			skid_data_r <= in_data;
			in_ready <= 1'b0;
		end
	end
end

endmodule // crs_skid_buf

// ### verif/crs_req_framer_properties.sv
/*
 * Checker of the request stream port: framing, keep, sop and hold.
 * Assumes it is bound to crs_req_framer with one clock and async reset.
 */
`timescale 1ns/1ps
`include "crs_regs.vh"
module crs_req_framer_chk (
	input wire core_clk,
	input wire reset_n,
	input wire req_stream_valid,
	input wire req_stream_ready,
	input wire [`CRS_DATA_W-1:0] req_stream_data,
	input wire [`CRS_KEEP_W-1:0] req_stream_dword_keep,
	input wire req_stream_last,
	input wire [`CRS_USER_W-1:0] req_stream_sideband
);
// ****************
// Helpers
// ****************
wire [7:0] k = req_stream_dword_keep;
wire sop = req_stream_sideband[`CRS_U_SOP];
wire [31:0] ben = req_stream_sideband[`CRS_U_BEN_HI:`CRS_U_BEN_LO];
wire [31:0] kmask = {{4{k[7]}}, {4{k[6]}}, {4{k[5]}}, {4{k[4]}},
	{4{k[3]}}, {4{k[2]}}, {4{k[1]}}, {4{k[0]}}};
wire [3:0] t = req_stream_data[`CRS_D_TYPE_HI:`CRS_D_TYPE_LO];
wire valid = req_stream_valid;
reg in_pkt_r;
wire in_pkt_nxt;
// Tracks whether an accepted beat left a packet open
assign in_pkt_nxt = (valid && req_stream_ready) ? !req_stream_last : in_pkt_r;
always @(posedge core_clk or negedge reset_n) begin
	if (!reset_n) begin
		in_pkt_r <= 1'b0;
	end else begin
		in_pkt_r <= in_pkt_nxt;
	end
end
default clocking cb @(posedge core_clk);
endclocking
default disable iff (!reset_n);
// ****************
// Properties
// ****************
hold_stable_a: assert property (
	valid && !req_stream_ready |=> valid && $stable(req_stream_data) &&
	$stable(k) && $stable(req_stream_last) && $stable(req_stream_sideband))
	else $error("beat changed while stalled");
keep_contig_a: assert property (
	valid |-> k[0] && ((k & (k + 8'h01)) == 8'h00))
	else $error("keep not contiguous");
keep_full_a: assert property (
	valid && !req_stream_last |-> k == 8'hff)
	else $error("short keep before final beat");
sop_desc_a: assert property (
	valid && sop |-> k[3:0] == 4'hf && ben[15:0] == 16'h0000)
	else $error("descriptor beat malformed");
sop_first_a: assert property (
	valid && !in_pkt_r |-> sop)
	else $error("packet start without sop");
no_sop_mid_a: assert property (
	valid && in_pkt_r |-> !sop)
	else $error("sop inside packet");
valid_held_a: assert property (
	in_pkt_r |-> valid)
	else $error("valid dropped inside packet");
ben_inside_a: assert property (
	valid |-> (ben & ~kmask) == 32'h0)
	else $error("byte enable outside kept dwords");
type_legal_a: assert property (
	valid && sop |-> t <= 4'h7 || (t >= 4'hc && t != 4'hf))
	else $error("illegal request type on stream");
endmodule // crs_req_framer_chk

bind crs_req_framer crs_req_framer_chk chk (.core_clk, .reset_n,
	.req_stream_valid, .req_stream_ready, .req_stream_data,
	.req_stream_dword_keep, .req_stream_last, .req_stream_sideband);

// ### verif/crs_user_sink.sv
/*
 * Completer user logic model: takes stream beats, optionally stalling,
 * and toggles its error report for a message code it does not support.
 * Assumes the bench records accepted beats itself.
 */
`timescale 1ns/1ps
module crs_user_sink (
	input wire core_clk,
	input wire reset_n,
	input wire slow,
	input wire req_stream_valid,
	input wire sop,
	input wire [3:0] req_type,
	input wire [7:0] msg_code,
	output reg req_stream_ready,
	output reg uncor_err_r
);
reg [1:0] cnt_r;
wire ur_msg;
// Only the OBFF message code (8'h12) is supported by this model
assign ur_msg = req_stream_valid && req_stream_ready && sop &&
	(req_type[3:2] == 2'b11) && (req_type != 4'hf) && (msg_code != 8'h12);
always @(posedge core_clk or negedge reset_n) begin
	if (!reset_n) begin
		cnt_r <= 2'h0;
		req_stream_ready <= 1'b0;
		uncor_err_r <= 1'b0;
	end else begin
		cnt_r <= #1 cnt_r + 2'h1;
		if (ur_msg)
			uncor_err_r <= #1 !uncor_err_r;
		// Stall three of four cycles so the buffer fills
		req_stream_ready <= #1 !slow || (cnt_r == 2'h3);
	end
end
endmodule // crs_user_sink

// ### verif/tb_crs_req_framer.sv
/*
 * Bench of the request framer: headers and payload in, stream beats out.
 * Assumes the user sink model drives ready; checker bound separately.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_crs_req_framer;
reg core_clk = 1'b0, reset_n = 1'b0, addr_aligned_mode = 1'b0, slow = 1'b0;
reg hdr_valid = 1'b0, hdr_has_data = 1'b0, pay_valid = 1'b0, dseen = 1'b0;
reg hdr_tph_present = 1'b0;
reg [3:0] hdr_type = 4'h0, hdr_first_dword_enables = 4'h0, hdr_last_be = 4'h0;
reg [63:0] hdr_addr = 64'h0;
reg [10:0] hdr_dw_count = 11'h0;
reg [15:0] hdr_req_id = 16'h0;
reg [7:0] hdr_tag = 8'h0, hdr_func = 8'h0, hdr_msg_code = 8'h0;
reg [7:0] hdr_tph_tag = 8'h0;
reg [2:0] hdr_bar_id = 3'h0, hdr_tc = 3'h0, hdr_attr = 3'h0;
reg [2:0] hdr_msg_route = 3'h0;
reg [1:0] hdr_tph_type = 2'h0;
reg [31:0] hdr_dw2 = 32'h0, hdr_dw3 = 32'h0, pay_dword = 32'h0;
wire hdr_ready, pay_ready, req_stream_valid, req_stream_ready;
wire req_stream_last, dropped_req, uncor_err;
wire [255:0] req_stream_data;
wire [7:0] req_stream_dword_keep;
wire [51:0] req_stream_sideband;
integer failures = 0, n_checks = 0, t;
reg [255:0] bd[$];
reg [7:0] bk[$];
reg bl[$];
reg [51:0] bs[$];
reg [31:0] pq[$];
reg [3:0] ob[3] = '{4'hf, 4'h1, 4'h0};

crs_req_framer dut (
	.core_clk(core_clk), .reset_n(reset_n),
	.addr_aligned_mode(addr_aligned_mode),
	.hdr_valid(hdr_valid), .hdr_ready(hdr_ready), .hdr_type(hdr_type),
	.hdr_has_data(hdr_has_data), .hdr_addr(hdr_addr),
	.hdr_dw_count(hdr_dw_count), .hdr_req_id(hdr_req_id),
	.hdr_tag(hdr_tag), .hdr_func(hdr_func), .hdr_bar_id(hdr_bar_id),
	.hdr_tc(hdr_tc), .hdr_attr(hdr_attr), .hdr_first_dword_enables(hdr_first_dword_enables),
	.hdr_last_be(hdr_last_be), .hdr_msg_code(hdr_msg_code),
	.hdr_msg_route(hdr_msg_route), .hdr_dw2(hdr_dw2), .hdr_dw3(hdr_dw3),
	.hdr_tph_present(hdr_tph_present), .hdr_tph_type(hdr_tph_type),
	.hdr_tph_tag(hdr_tph_tag), .pay_valid(pay_valid),
	.pay_ready(pay_ready), .pay_dword(pay_dword),
	.req_stream_valid(req_stream_valid),
	.req_stream_ready(req_stream_ready),
	.req_stream_data(req_stream_data),
	.req_stream_dword_keep(req_stream_dword_keep),
	.req_stream_last(req_stream_last),
	.req_stream_sideband(req_stream_sideband),
	.dropped_req(dropped_req)
);
crs_user_sink sink (.core_clk(core_clk), .reset_n(reset_n), .slow(slow),
	.req_stream_valid(req_stream_valid), .sop(req_stream_sideband[40]),
	.req_type(req_stream_data[78:75]),
	.msg_code(req_stream_data[111:104]),
	.req_stream_ready(req_stream_ready), .uncor_err_r(uncor_err));

always #12.5 core_clk = ~core_clk;

// ****************
// Monitor and payload source
// ****************
// Outputs are stable from the falling edge to the accepting rising edge
always @(negedge core_clk) begin
	if (req_stream_valid === 1'b1 && req_stream_ready === 1'b1) begin
		bd.push_back(req_stream_data);
		bk.push_back(req_stream_dword_keep);
		bl.push_back(req_stream_last);
		bs.push_back(req_stream_sideband);
	end
	if (pay_valid && pay_ready === 1'b1)
		void'(pq.pop_front());
	if (dropped_req === 1'b1)
		dseen = 1'b1;
end
always @(posedge core_clk) begin
	#1;
	pay_valid = pq.size() != 0;
	pay_dword = pay_valid ? pq[0] : 32'h0;
end

// ****************
// Tasks
// ****************
task hdr(input [3:0] ty, input d, input [63:0] a, input [10:0] n,
	input [3:0] fb, input [3:0] lb);
	integer j;
	begin
		bd.delete();
		bk.delete();
		bl.delete();
		bs.delete();
		dseen = 1'b0;
		@(posedge core_clk);
		#1;
		{hdr_type, hdr_has_data, hdr_addr} = {ty, d, a};
		{hdr_dw_count, hdr_first_dword_enables, hdr_last_be} = {n, fb, lb};
		hdr_valid = 1'b1;
		j = 0;
		do begin
			@(negedge core_clk);
			j++;
		end while (hdr_ready !== 1'b1 && j < 100);
		@(posedge core_clk);
		#1;
		hdr_valid = 1'b0;
		if (j >= 100) begin
			failures++;
			$display("unexpected at %0t: header not taken", $time);
		end
		for (j = 0; j < n && d; j++)
			pq.push_back(32'hd0000000 + j);
	end
endtask
task wt(input integer k);
	integer j;
	begin
		for (j = 0; j < 300 && bd.size() < k; j++)
			@(posedge core_clk);
		repeat (8) @(posedge core_clk);
		`CHK(bd.size(), k)
	end
endtask
task wrap_up;
	begin
		$display("failures=%0d n_checks=%0d", failures, n_checks);
		if (failures == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end
endtask

initial begin
	#500000;
	failures++;
	$display("unexpected at %0t: timeout", $time);
	wrap_up;
end

// ****************
// Tests
// ****************
initial begin
	repeat (3) @(posedge core_clk);
	#1;
	reset_n = 1'b1;
	hdr_attr = 3'h5;
	slow = 1'b1;
	hdr(4'h1, 1'b1, 64'h1004, 11'd5, 4'he, 4'h3);
	wt(2);
	`CHK(bd[0][159:128], 32'hd0000000)
	`CHK(bd[0][78:64], {4'h1, 11'd5})
	`CHK(bd[0][63:2], 62'h401)
	`CHK(bd[0][126:124], 3'h5)
	`CHK({bk[0], bk[1], bl[0], bl[1]}, 18'h3fc05)
	`CHK(bs[0][40:0], {1'b1, 32'hfffe0000, 8'h3e})
	`CHK(bs[1][40:8], 33'h3)
	`CHK(bd[1][31:0], 32'hd0000004)
	addr_aligned_mode = 1'b1;
	{hdr_tph_present, hdr_tph_type, hdr_tph_tag} = {1'b1, 2'h2, 8'h5a};
	hdr(4'h1, 1'b1, 64'h2014, 11'd2, 4'hc, 4'h7);
	wt(2);
	`CHK({bk[0], bk[1]}, 16'hff7f)
	`CHK(bd[1][223:160], 64'hd0000001_d0000000)
	`CHK(bs[1][39:8], 32'h07c00000)
	`CHK(bs[0][51:41], {8'h5a, 2'h2, 1'b1})
	addr_aligned_mode = 1'b0;
	hdr_tph_present = 1'b0;
	hdr(4'h1, 1'b1, 64'h3000, 11'd1, 4'h0, 4'h0);
	wt(1);
	`CHK({bk[0], bl[0]}, 9'h03f)
	`CHK(bs[0][39:8], 32'h0)
	slow = 1'b0;
	{hdr_msg_route, hdr_dw2, hdr_dw3} = {3'h2, 64'h12345678_9abcdef0};
	for (t = 0; t < 16; t++) begin
		hdr_msg_code = 8'h30 + t[7:0];
		hdr_req_id = t[15:0];
		hdr(t[3:0], 1'b0, 64'h40, 11'd1, 4'hf, 4'h0);
		if (t[3:2] == 2'b10 || t == 15) begin
			wt(0);
			`CHK(dseen, 1'b1)
		end else begin
			wt(1);
			`CHK(bd[0][78:75], t[3:0])
			`CHK({bk[0], bl[0]}, 9'h01f)
		end
		if (t >= 12 && t < 15) begin
			`CHK(bd[0][114:104], {3'h2, 8'h30 + t[7:0]})
			`CHK(uncor_err, !t[0])
		end
		if (t == 13)
			`CHK({bd[0][63:32], bd[0][15:0]}, 48'h9abcdef0_1234)
		if (t == 14)
			`CHK(bd[0][63:0], 64'h9abcdef0_12345678)
	end
	hdr_msg_code = 8'h12;
	for (t = 0; t < 3; t++) begin
		hdr_dw3 = {28'h0, ob[t]};
		hdr(4'hc, 1'b0, 64'h0, 11'd1, 4'h0, 4'h0);
		wt(1);
		`CHK(bd[0][35:32], ob[t])
		`CHK(uncor_err, 1'b1)
	end
	hdr(4'ha, 1'b1, 64'h0, 11'd3, 4'hf, 4'hf);
	wt(0);
	`CHK({dseen, pq.size() == 0}, 2'b11)
	wrap_up;
end
endmodule // tb_crs_req_framer
